// >>> hdl/ppg_pkg.sv
// constants and carrier types for the pin interrupt and shared port block
package ppg_pkg;

  localparam int PPG_ADDR_W = 10;
  localparam int PPG_DATA_W = 8;
  localparam int PPG_HV_N = 4;
  localparam int PPG_SH_N = 6;
  localparam int PPG_SYNC_W = 10;

  // register byte addresses
  localparam logic [9:0] PPG_OFF_HV_POL = 10'h26d;
  localparam logic [9:0] PPG_OFF_HV_EN = 10'h26e;
  localparam logic [9:0] PPG_OFF_HV_FLAG = 10'h26f;
  localparam logic [9:0] PPG_OFF_SH_DATA = 10'h271;
  localparam logic [9:0] PPG_OFF_SH_LEVEL = 10'h272;
  localparam logic [9:0] PPG_OFF_SH_DIR = 10'h273;
  localparam logic [9:0] PPG_OFF_SH_PULL = 10'h274;
  localparam logic [9:0] PPG_OFF_SH_POL = 10'h275;

  // field positions within the bus byte
  localparam int PPG_HV_LSB = 0;
  localparam int PPG_SH_LSB = 0;

  // values after reset
  localparam logic [3:0] PPG_RST_HV_POL = 4'h0;
  localparam logic [3:0] PPG_RST_HV_EN = 4'h0;
  localparam logic [3:0] PPG_RST_HV_FLAG = 4'h0;
  localparam logic [5:0] PPG_RST_SH_DATA = 6'h00;
  localparam logic [5:0] PPG_RST_SH_DIR = 6'h00;
  localparam logic [5:0] PPG_RST_SH_PULL = 6'h00;
  localparam logic [5:0] PPG_RST_SH_POL = 6'h00;
  localparam logic [5:0] PPG_RST_PULL_UP = 6'h3f;
  localparam logic [7:0] PPG_RST_RDATA = 8'h00;
  localparam logic [9:0] PPG_RST_SYNC = 10'h000;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ppg_bus_t;

  typedef struct packed {
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [5:0] pull_on;
    logic [5:0] pull_up;
  } ppg_pads_t;

endpackage : ppg_pkg

// >>> hdl/ppg_port.sv
// pin interrupt group and converter-shared general purpose port
`timescale 1ns/1ps

module ppg_port
  import ppg_pkg::*;
(
  input wire logic mclk, // bus clock, 10 MHz
  input wire logic rst, // synchronous reset, active high
  input wire ppg_bus_t bus, // register bus request
  output logic [7:0] rdata, // read data, cycle after read strobe
  input wire logic [3:0] hv_pin_in, // interrupt-capable input pins
  input wire logic [5:0] sh_pin_in, // shared port pin levels
  input wire logic [5:0] converter_digital_input_enable, // from converter
  input wire logic [5:0] converter_pin_claim, // converter owns pin
  output ppg_pads_t pads, // shared port pad controls
  output logic irq // pin interrupt request
);

  typedef struct packed {
    logic primed;
    logic [3:0] hv_prev;
    logic [3:0] hv_edge_polarity_bits;
    logic [3:0] hv_irq_enable_bits;
    logic [3:0] hv_irq_flag_bits;
    logic [5:0] shared_port_data_bits;
    logic [5:0] shared_port_direction_bits;
    logic [5:0] shared_port_pull_enable_bits;
    logic [5:0] shared_port_polarity_bits;
    logic [7:0] rdata;
    logic irq;
    ppg_pads_t pads;
  } ppg_state_t;

  ppg_state_t st;
  ppg_state_t next_st;
  logic [9:0] sync_q;
  logic [3:0] hv_lvl;
  logic [5:0] sh_lvl;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] det;
  logic [3:0] clr;
  logic wr_hit_flag;

  // pad a four-bit field into a bus byte
  function automatic logic [7:0] byte4(input logic [3:0] v);
    byte4 = {4'h0, v};
  endfunction

  // pad a six-bit field into a bus byte
  function automatic logic [7:0] byte6(input logic [5:0] v);
    byte6 = {2'h0, v};
  endfunction

  // pin as seen by software; disabled input buffer reads 1
  function automatic logic [5:0] level_view(
    input logic [5:0] lvl,
    input logic [5:0] dien
  );
    level_view = (dien & lvl) | ~dien;
  endfunction

  ppg_sync #(
    .W(PPG_SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({sh_pin_in, hv_pin_in}),
    .q(sync_q)
  );

  assign hv_lvl = sync_q[3:0];
  assign sh_lvl = sync_q[9:4];

  // edge detection on successive samples
  always_comb
  begin
    rise = hv_lvl & ~st.hv_prev;
    fall = ~hv_lvl & st.hv_prev;
    if (st.primed)
    begin
      det = (rise & st.hv_edge_polarity_bits) |
            (fall & ~st.hv_edge_polarity_bits);
    end
    else
    begin
      det = 4'h0;
    end
    wr_hit_flag = bus.wr && (bus.addr == PPG_OFF_HV_FLAG);
    if (wr_hit_flag)
    begin
      clr = bus.wdata[3:0];
    end
    else
    begin
      clr = 4'h0;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.primed = 1'b1;
    next_st.hv_prev = hv_lvl;
    // edge set wins over a same-cycle clear
    next_st.hv_irq_flag_bits = (st.hv_irq_flag_bits & ~clr) | det;
    if (bus.wr)
    begin
      case (bus.addr)
        PPG_OFF_HV_POL:
        begin
          next_st.hv_edge_polarity_bits = bus.wdata[3:0];
        end
        PPG_OFF_HV_EN:
        begin
          next_st.hv_irq_enable_bits = bus.wdata[3:0];
        end
        PPG_OFF_SH_DATA:
        begin
          next_st.shared_port_data_bits = bus.wdata[5:0];
        end
        PPG_OFF_SH_DIR:
        begin
          next_st.shared_port_direction_bits = bus.wdata[5:0];
        end
        PPG_OFF_SH_PULL:
        begin
          next_st.shared_port_pull_enable_bits = bus.wdata[5:0];
        end
        PPG_OFF_SH_POL:
        begin
          next_st.shared_port_polarity_bits = bus.wdata[5:0];
        end
        default:
        begin
          // flag writes handled above; level register ignores writes
          next_st.primed = 1'b1;
        end
      endcase
    end
    next_st.rdata = PPG_RST_RDATA;
    if (bus.rd)
    begin
      case (bus.addr)
        PPG_OFF_HV_POL:
        begin
          next_st.rdata = byte4(st.hv_edge_polarity_bits);
        end
        PPG_OFF_HV_EN:
        begin
          next_st.rdata = byte4(st.hv_irq_enable_bits);
        end
        PPG_OFF_HV_FLAG:
        begin
          next_st.rdata = byte4(st.hv_irq_flag_bits);
        end
        PPG_OFF_SH_DATA:
        begin
          next_st.rdata = byte6(
            (st.shared_port_direction_bits & st.shared_port_data_bits) |
            (~st.shared_port_direction_bits &
             level_view(sh_lvl, converter_digital_input_enable))
          );
        end
        PPG_OFF_SH_LEVEL:
        begin
          next_st.rdata = byte6(
            level_view(sh_lvl, converter_digital_input_enable)
          );
        end
        PPG_OFF_SH_DIR:
        begin
          next_st.rdata = byte6(st.shared_port_direction_bits);
        end
        PPG_OFF_SH_PULL:
        begin
          next_st.rdata = byte6(st.shared_port_pull_enable_bits);
        end
        PPG_OFF_SH_POL:
        begin
          next_st.rdata = byte6(st.shared_port_polarity_bits);
        end
        default:
        begin
          next_st.rdata = PPG_RST_RDATA;
        end
      endcase
    end
    // masked flags still stored, only the request is gated
    next_st.irq = |(next_st.hv_irq_flag_bits &
                    next_st.hv_irq_enable_bits);
    // pads follow the updated registers; a converter claim clears only pin_oe and pull_on
    next_st.pads.pin_out = next_st.shared_port_data_bits;
    next_st.pads.pin_oe = next_st.shared_port_direction_bits &
                          ~converter_pin_claim;
    next_st.pads.pull_on = next_st.shared_port_pull_enable_bits &
                           ~next_st.shared_port_direction_bits &
                           ~converter_pin_claim;
    next_st.pads.pull_up = ~next_st.shared_port_polarity_bits;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st.primed <= 1'b0;
      st.hv_prev <= PPG_RST_HV_FLAG;
      st.hv_edge_polarity_bits <= PPG_RST_HV_POL;
      st.hv_irq_enable_bits <= PPG_RST_HV_EN;
      st.hv_irq_flag_bits <= PPG_RST_HV_FLAG;
      st.shared_port_data_bits <= PPG_RST_SH_DATA;
      st.shared_port_direction_bits <= PPG_RST_SH_DIR;
      st.shared_port_pull_enable_bits <= PPG_RST_SH_PULL;
      st.shared_port_polarity_bits <= PPG_RST_SH_POL;
      st.rdata <= PPG_RST_RDATA;
      st.irq <= 1'b0;
      st.pads.pin_out <= PPG_RST_SH_DATA;
      st.pads.pin_oe <= PPG_RST_SH_DIR;
      st.pads.pull_on <= PPG_RST_SH_PULL;
      st.pads.pull_up <= PPG_RST_PULL_UP;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq = st.irq;
  assign pads = st.pads;

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (rst);

  // per-pin edge to flag and flag write-clear checks
  for (genvar i = 0; i < PPG_HV_N; i++)
  begin : g_chk
    AST_RISE_SETS_FLAG:
      assert property (st.primed && rise[i] && st.hv_edge_polarity_bits[i]
                       |=> st.hv_irq_flag_bits[i])
      else $error("rising edge with polarity 1 did not set flag");
    AST_FALL_SETS_FLAG:
      assert property (st.primed && fall[i] && !st.hv_edge_polarity_bits[i]
                       |=> st.hv_irq_flag_bits[i])
      else $error("falling edge with polarity 0 did not set flag");
    AST_WRONG_EDGE_IGNORED:
      assert property (!det[i] && !st.hv_irq_flag_bits[i] && !clr[i]
                       |=> !st.hv_irq_flag_bits[i])
      else $error("flag set without a selected edge");
    AST_W1C_CLEARS:
      assert property (wr_hit_flag && bus.wdata[i] && !det[i]
                       |=> !st.hv_irq_flag_bits[i])
      else $error("write one did not clear flag");
    AST_W0_KEEPS:
      assert property (wr_hit_flag && !bus.wdata[i] &&
                       st.hv_irq_flag_bits[i]
                       |=> st.hv_irq_flag_bits[i])
      else $error("write zero disturbed a flag");
  end

  AST_IRQ_FOLLOWS:
    assert property (irq == |(st.hv_irq_flag_bits & st.hv_irq_enable_bits))
    else $error("interrupt output not flags gated by enables");

  AST_MASKED_QUIET:
    assert property ((st.hv_irq_enable_bits == 4'h0) |-> !irq)
    else $error("interrupt raised with all enables clear");

  AST_DATA_READ:
    assert property (bus.rd && bus.addr == PPG_OFF_SH_DATA
                     |=> (rdata[5:0] & $past(st.shared_port_direction_bits))
                         == ($past(st.shared_port_data_bits) &
                             $past(st.shared_port_direction_bits)))
    else $error("output pins did not read stored data");

  AST_DATA_INPUT:
    assert property (bus.rd && bus.addr == PPG_OFF_SH_DATA
                     |=> ((rdata[5:0] ^ $past(sh_lvl)) &
                          ~$past(st.shared_port_direction_bits) &
                          $past(converter_digital_input_enable)) == 6'h00)
    else $error("input pins did not read the pin level");

  AST_LEVEL_DISABLED:
    assert property (bus.rd && bus.addr == PPG_OFF_SH_LEVEL &&
                     converter_digital_input_enable == 6'h00
                     |=> rdata == 8'h3f)
    else $error("disabled input buffer did not read as one");

  AST_LEVEL_READ:
    assert property (bus.rd && bus.addr == PPG_OFF_SH_LEVEL
                     |=> ((rdata[5:0] ^ $past(sh_lvl)) &
                          $past(converter_digital_input_enable)) == 6'h00)
    else $error("level register did not show the pin level");

  AST_LEVEL_RO:
    assert property (bus.wr && bus.addr == PPG_OFF_SH_LEVEL
                     |=> $stable(st.shared_port_data_bits) &&
                         $stable(st.shared_port_direction_bits))
    else $error("write to level register changed state");

  AST_READ_ONE_CYCLE:
    assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data present without a read");

  AST_DRIVE:
    assert property (pads.pin_oe ==
                     (st.shared_port_direction_bits &
                      ~$past(converter_pin_claim)) &&
                     pads.pin_out == st.shared_port_data_bits)
    else $error("pad drive not from direction and data");

  AST_PULL_OFF_OUT:
    assert property ((pads.pull_on & st.shared_port_direction_bits) == 6'h00
                     && pads.pull_up == ~st.shared_port_polarity_bits)
    else $error("pull active on output or wrong pull direction");

  AST_CLAIM_RELEASES:
    assert property ((pads.pull_on & $past(converter_pin_claim)) == 6'h00)
    else $error("claimed pin still has a pull device");

endmodule // ppg_port

// >>> hdl/ppg_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module ppg_sync
  import ppg_pkg::*;
#(
  parameter int W = PPG_SYNC_W
)
(
  input wire logic mclk, // bus clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppg_sync_st_t;

  ppg_sync_st_t st;
  ppg_sync_st_t next_st;

  always_comb
  begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule // ppg_sync

// >>> verification/port_pin_irq_and_analog_gpio_tb_top.sv
// self-checking bench for the pin interrupt and shared port block
`timescale 1ns/1ps
module port_pin_irq_and_analog_gpio_tb_top;
  import ppg_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  ppg_bus_t bus = '0;
  logic [7:0] rdata;
  logic [3:0] hv = 4'h0;
  logic [5:0] sh_pin;
  logic [5:0] dien = 6'h00;
  logic [5:0] claim = 6'h00;
  ppg_pads_t pads;
  logic irq;
  logic [5:0] ext_lvl = 6'h00;
  logic [5:0] ext_drv = 6'h00;
  logic [5:0] ext_short = 6'h00;
  logic [9:0] cfg_offs [6] = '{PPG_OFF_HV_POL, PPG_OFF_HV_EN,
    PPG_OFF_HV_FLAG, PPG_OFF_SH_DIR, PPG_OFF_SH_PULL, PPG_OFF_SH_POL};
  int failures = 0;
  int checks_done = 0;

  ppg_port ppg_port_inst (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
    .hv_pin_in(hv), .sh_pin_in(sh_pin),
    .converter_digital_input_enable(dien), .converter_pin_claim(claim),
    .pads(pads), .irq(irq));

  ppg_pin_model ppg_pin_model_inst (.mclk(mclk), .pads(pads),
    .ext_lvl(ext_lvl), .ext_drv(ext_drv), .ext_short(ext_short),
    .pin(sh_pin));

  initial
  begin
    forever #50 mclk = ~mclk;
  end

  task automatic report_and_stop;
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // cuts a hang short
  initial
  begin
    #5000000;
    failures++;
    report_and_stop;
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    chk({7'h00, irq}, 8'h00);
    chk({2'b00, pads.pull_up}, 8'h3f);
    chk({2'b00, pads.pin_oe}, 8'h00);
    for (int i = 0; i < 6; i++)
      rd(cfg_offs[i], 8'h00);
    rd(10'h270, 8'h00);
    rd(PPG_OFF_SH_DATA, 8'h3f);
    rd(PPG_OFF_SH_LEVEL, 8'h3f);
    // interrupt pins: 0 and 2 rising, 1 and 3 falling
    wr(PPG_OFF_HV_POL, 8'h05);
    rd(PPG_OFF_HV_POL, 8'h05);
    @(posedge mclk);
    hv <= 4'hf;
    tick(5);
    rd(PPG_OFF_HV_FLAG, 8'h05);
    chk({7'h00, irq}, 8'h00);
    wr(PPG_OFF_HV_EN, 8'h02);
    tick(2);
    chk({7'h00, irq}, 8'h00);
    @(posedge mclk);
    hv <= 4'h0;
    tick(5);
    rd(PPG_OFF_HV_FLAG, 8'h0f);
    chk({7'h00, irq}, 8'h01);
    wr(PPG_OFF_HV_FLAG, 8'h05);
    rd(PPG_OFF_HV_FLAG, 8'h0a);
    chk({7'h00, irq}, 8'h01);
    wr(PPG_OFF_HV_FLAG, 8'h02);
    rd(PPG_OFF_HV_FLAG, 8'h08);
    chk({7'h00, irq}, 8'h00);
    wr(PPG_OFF_HV_EN, 8'h08);
    tick(2);
    chk({7'h00, irq}, 8'h01);
    wr(PPG_OFF_HV_FLAG, 8'h08);
    tick(2);
    chk({7'h00, irq}, 8'h00);
    // shared port: low nibble outputs, top two pins driven from outside
    @(posedge mclk);
    dien <= 6'h3f;
    ext_lvl <= 6'h15;
    ext_drv <= 6'h3f;
    wr(PPG_OFF_SH_DATA, 8'h2a);
    wr(PPG_OFF_SH_DIR, 8'h0f);
    tick(4);
    chk({2'b00, pads.pin_oe}, 8'h0f);
    chk({2'b00, pads.pin_out & pads.pin_oe}, 8'h0a);
    rd(PPG_OFF_SH_DIR, 8'h0f);
    rd(PPG_OFF_SH_DATA, 8'h1a);
    rd(PPG_OFF_SH_LEVEL, 8'h1a);
    // output pin 0 pulled high by an outside short
    @(posedge mclk);
    ext_short <= 6'h01;
    tick(4);
    rd(PPG_OFF_SH_LEVEL, 8'h1b);
    rd(PPG_OFF_SH_DATA, 8'h1a);
    @(posedge mclk);
    ext_short <= 6'h00;
    dien <= 6'h0f;
    tick(4);
    wr(PPG_OFF_SH_LEVEL, 8'h00);
    rd(PPG_OFF_SH_LEVEL, 8'h3a);
    rd(PPG_OFF_SH_DATA, 8'h3a);
    // pulls on the released input pins
    @(posedge mclk);
    dien <= 6'h3f;
    ext_drv <= 6'h00;
    wr(PPG_OFF_SH_PULL, 8'h3f);
    wr(PPG_OFF_SH_POL, 8'h10);
    tick(4);
    chk({2'b00, pads.pull_on}, 8'h30);
    chk({2'b00, pads.pull_up & pads.pull_on}, 8'h20);
    rd(PPG_OFF_SH_LEVEL, 8'h2a);
    rd(PPG_OFF_SH_PULL, 8'h3f);
    rd(PPG_OFF_SH_POL, 8'h10);
    @(posedge mclk);
    claim <= 6'h01;
    tick(2);
    chk({2'b00, pads.pin_oe}, 8'h0e);
    // mid-run reset returns registers and pads to idle
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    chk({7'h00, irq}, 8'h00);
    chk({2'b00, pads.pin_oe | pads.pull_on}, 8'h00);
    chk({2'b00, pads.pull_up}, 8'h3f);
    rd(PPG_OFF_SH_DIR, 8'h00);
    rd(PPG_OFF_HV_POL, 8'h00);
    report_and_stop;
  end
endmodule // port_pin_irq_and_analog_gpio_tb_top

// >>> verification/ppg_pin_model.sv
// far-side model of the shared port pins and external drivers
`timescale 1ns/1ps
module ppg_pin_model
  import ppg_pkg::*;
(
  input wire logic mclk, // bus clock
  input wire ppg_pads_t pads, // pad controls from the port
  input wire logic [5:0] ext_lvl, // level of the external source
  input wire logic [5:0] ext_drv, // external source drives an input pin
  input wire logic [5:0] ext_short, // external source overpowers output
  output logic [5:0] pin // resolved pin level
);
  logic [5:0] float_lvl = 6'h15;

  // an undriven, unpulled pin holds no stable level
  always @(posedge mclk)
    float_lvl <= ~float_lvl;

  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (ext_short[i])
        pin[i] = ext_lvl[i];
      else if (pads.pin_oe[i])
        pin[i] = pads.pin_out[i];
      else if (ext_drv[i])
        pin[i] = ext_lvl[i];
      else if (pads.pull_on[i])
        pin[i] = pads.pull_up[i];
      else
        pin[i] = float_lvl[i];
    end
  end
endmodule // ppg_pin_model
